// [verilog/awts_defs.vh]
// constants for the scan wrap and trigger source select block
`ifndef AWTS_DEFS_VH
`define AWTS_DEFS_VH
`define AWTS_ADDR_WRAP 4'h0
`define AWTS_ADDR_TRIG 4'h4
`define AWTS_ADDR_STAT 4'h8
`define AWTS_CLASS_BIT 7
`define AWTS_WRAP_RESET 4'hF
`define AWTS_TRIG_RESET 5'h00
`endif

// [verilog/awts_top.v]
// scan wrap and trigger source select registers with a small scan sequencer
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`include "awts_defs.vh"
module awts_top #(
    parameter HAS_DEDICATED = 1
) (
    input wire CLOCK,
    input wire RST_N,
    input wire CYC_I,
    input wire STB_I,
    input wire WE_I,
    input wire [3:0] ADR_I,
    input wire [3:0] SEL_I,
    input wire [31:0] DAT_I,
    output reg [31:0] DAT_O,
    output reg ACK_O,
    input wire START,
    input wire MULTI_CHANNEL_MODE,
    input wire EXTERNAL_TRIGGER_ENABLE,
    input wire CONV_DONE,
    input wire [3:0] DEDICATED_TRIGGER_INPUTS,
    input wire [15:0] ANALOG_PINS,
    output reg ABORT,
    output reg BUSY,
    output reg [3:0] CHANNEL,
    output reg TRIGGER_LEVEL,
    output reg [15:0] INPUT_BUFFER_EN
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN = 2'b10;
    reg [3:0] wrap_reg;
    reg [4:0] trig_reg;
    reg [1:0] state_reg;

    // next values of the registers
    reg [1:0] state_next;
    reg busy_next;
    reg abort_next;
    reg [3:0] channel_next;
    reg trigger_level_next;
    reg [15:0] input_buffer_en_next;
    reg ack_next;
    reg [31:0] dat_o_next;
    reg [3:0] wrap_next;
    reg [4:0] trig_next;

    // synchronised pins and decode helpers
    wire [3:0] ded_sync;
    wire [15:0] an_sync;
    wire [1:0] ded_index;
    wire ded_in_range;
    wire wrap_hit;

    wire req = CYC_I & STB_I & ~ACK_O;
    wire wr_lane0 = req & WE_I & SEL_I[0];
    wire wr_wrap = wr_lane0 & (ADR_I == `AWTS_ADDR_WRAP);
    wire wr_trig = wr_lane0 & (ADR_I == `AWTS_ADDR_TRIG);
    wire ctl_write = wr_wrap | wr_trig;
    wire use_ded = trig_reg[4] & (HAS_DEDICATED != 0);
    reg [31:0] rd_data;
    always @* begin
        case (ADR_I)
            `AWTS_ADDR_WRAP: rd_data = {28'h0000000, wrap_reg};
            `AWTS_ADDR_TRIG: rd_data = {24'h000000, trig_reg[4], 3'h0, trig_reg[3:0]};
            `AWTS_ADDR_STAT: rd_data = {31'h00000000, BUSY};
            default: rd_data = 32'h00000000;
        endcase
    end

    // register bus next values
    always @* begin
        ack_next = req;
        dat_o_next = DAT_O;
        wrap_next = wrap_reg;
        trig_next = trig_reg;
        if (req && !WE_I) begin
            dat_o_next = rd_data;
        end
        if (wr_wrap) begin
            wrap_next = DAT_I[3:0];
        end
        if (wr_trig) begin
            trig_next = {DAT_I[`AWTS_CLASS_BIT], DAT_I[3:0]};
        end
    end

    // register bus flops
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h00000000;
            wrap_reg <= `AWTS_WRAP_RESET;
            trig_reg <= `AWTS_TRIG_RESET;
        end else begin
            ACK_O <= ack_next;
            DAT_O <= dat_o_next;
            wrap_reg <= wrap_next;
            trig_reg <= trig_next;
        end
    end

    // dedicated trigger and analog pins pass two flops before use
    awts_sync #(
        .WIDTH(4)
    ) i_awts_sync_ded (
        .clock(CLOCK),
        .rst_n(RST_N),
        .d_in(DEDICATED_TRIGGER_INPUTS),
        .q_out(ded_sync)
    );

    awts_sync #(
        .WIDTH(16)
    ) i_awts_sync_an (
        .clock(CLOCK),
        .rst_n(RST_N),
        .d_in(ANALOG_PINS),
        .q_out(an_sync)
    );

    assign ded_index = trig_reg[1:0];
    assign ded_in_range = (trig_reg[3:2] == 2'b00);

    // trigger source and buffer enable
    always @* begin
        if (use_ded) begin
            trigger_level_next = ded_in_range ? ded_sync[ded_index] : 1'b0;
        end else begin
            trigger_level_next = an_sync[trig_reg[3:0]];
        end
        if (EXTERNAL_TRIGGER_ENABLE && !use_ded) begin
            input_buffer_en_next = 16'h0001 << trig_reg[3:0];
        end else begin
            input_buffer_en_next = 16'h0000;
        end
    end

    // trigger output flops
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            TRIGGER_LEVEL <= 1'b0;
            INPUT_BUFFER_EN <= 16'h0000;
        end else begin
            TRIGGER_LEVEL <= trigger_level_next;
            INPUT_BUFFER_EN <= input_buffer_en_next;
        end
    end

    // last channel before wrapping
    assign wrap_hit = (CHANNEL == wrap_reg);

    // scan sequencer next state
    always @* begin
        state_next = state_reg;
        busy_next = BUSY;
        channel_next = CHANNEL;
        abort_next = ctl_write & BUSY;
        case (state_reg)
            ST_IDLE: begin
                if (START && !ctl_write) begin
                    state_next = ST_RUN;
                    busy_next = 1'b1;
                    channel_next = 4'h0;
                end
            end
            ST_RUN: begin
                if (ctl_write) begin
                    state_next = ST_IDLE;
                    busy_next = 1'b0;
                end else if (CONV_DONE && MULTI_CHANNEL_MODE) begin
                    if (wrap_hit) begin
                        channel_next = 4'h0;
                    end else begin
                        channel_next = CHANNEL + 4'h1;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
                busy_next = 1'b0;
            end
        endcase
    end

    // scan sequencer flops
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= ST_IDLE;
            BUSY <= 1'b0;
            ABORT <= 1'b0;
            CHANNEL <= 4'h0;
        end else begin
            state_reg <= state_next;
            BUSY <= busy_next;
            ABORT <= abort_next;
            CHANNEL <= channel_next;
        end
    end
endmodule

// two-flop synchroniser for pin inputs
module awts_sync #(
    parameter WIDTH = 1
) (
    input wire clock,
    input wire rst_n,
    input wire [WIDTH-1:0] d_in,
    output wire [WIDTH-1:0] q_out
);
    // first and second stage
    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;

    // only the second flop feeds logic
    assign q_out = s2_reg;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= {WIDTH{1'b0}};
            s2_reg <= {WIDTH{1'b0}};
        end else begin
            s1_reg <= d_in;
            s2_reg <= s1_reg;
        end
    end
endmodule

// [test/awts_checker.sv]
// assertions for the wrap and trigger select block
module awts_checker(input wire CLOCK, RST_N, CYC_I, STB_I, WE_I, ACK_O, ABORT, BUSY,
    input wire MULTI_CHANNEL_MODE, CONV_DONE, EXTERNAL_TRIGGER_ENABLE, input wire [3:0] ADR_I, SEL_I, CHANNEL,
    input wire [31:0] DAT_I, DAT_O, input wire [15:0] INPUT_BUFFER_EN);
    timeunit 1ns;
    timeprecision 1ns;
    reg [3:0] w_reg;
    reg [7:0] t_reg;
    wire rq = CYC_I && STB_I && !ACK_O;
    wire wr = rq && WE_I && SEL_I[0] && (ADR_I == 4'h0 || ADR_I == 4'h4);
    always @(posedge CLOCK or negedge RST_N)
        if (!RST_N) {w_reg, t_reg} <= 12'hF00;
        else if (wr && ADR_I[2]) t_reg <= DAT_I[7:0] & 8'h8F;
        else if (wr) w_reg <= DAT_I[3:0];
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    sequence s_kill; wr && BUSY; endsequence
    property p_ack; rq |=> ACK_O ##1 !ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("ack not one pulse");
    property p_abort; s_kill |=> ABORT && !BUSY ##1 !ABORT; endproperty
    a_abort: assert property (p_abort) else $error("no abort");
    property p_idle; wr && !BUSY |=> !BUSY && !ABORT; endproperty
    a_idle: assert property (p_idle) else $error("write started scan");
    property p_wrap; BUSY && MULTI_CHANNEL_MODE && CONV_DONE && !wr
        |=> CHANNEL == ($past(CHANNEL) == w_reg ? 4'h0 : $past(CHANNEL) + 4'h1); endproperty
    a_wrap: assert property (p_wrap) else $error("bad next channel");
    property p_buf; $past(EXTERNAL_TRIGGER_ENABLE) && $stable(t_reg) && !t_reg[7]
        |-> INPUT_BUFFER_EN == 16'h1 << t_reg[3:0]; endproperty
    a_buf: assert property (p_buf) else $error("buffer enable wrong");
    property p_bufoff; !$past(EXTERNAL_TRIGGER_ENABLE) |-> INPUT_BUFFER_EN == 16'h0; endproperty
    a_bufoff: assert property (p_bufoff) else $error("buffer on while off");
    property p_rdw; rq && !WE_I && ADR_I == 4'h0 |=> DAT_O == {28'h0, w_reg}; endproperty
    a_rdw: assert property (p_rdw) else $error("wrap readback");
    property p_rdt; rq && !WE_I && ADR_I == 4'h4 |=> DAT_O == {24'h0, t_reg}; endproperty
    a_rdt: assert property (p_rdt) else $error("trigger readback");
endmodule
bind awts_top awts_checker i_awts_checker(.*);

// [test/awts_top_test.sv]
// random register, trigger and scan test of the block
module awts_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLOCK = 0, RST_N = 0, CYC_I = 0, STB_I = 0, WE_I = 0, START = 0, CONV_DONE = 0, ACK_O, ABORT, BUSY;
    logic MULTI_CHANNEL_MODE = 1, EXTERNAL_TRIGGER_ENABLE = 0, TRIGGER_LEVEL;
    logic [3:0] ADR_I = 0, SEL_I = 4'hF, DEDICATED_TRIGGER_INPUTS = 0, CHANNEL, k;
    logic [31:0] DAT_I = 0, DAT_O;
    logic [15:0] ANALOG_PINS = 0, INPUT_BUFFER_EN;
    logic [7:0] w, rd, t;
    logic [31:0] r;
    int seed = 98, fail_count = 0, n_checks = 0;
    int n_abort = 0, it = 0;
    awts_top i_awts_top(.*);
    initial forever #25 CLOCK = ~CLOCK;
    always @(posedge CLOCK) if (ABORT === 1'b1) n_abort++;
    function automatic logic exp_level(input [7:0] v, input [15:0] an, input [3:0] ded);
        return v[7] ? ded[v[1:0]] : an[v[3:0]];
    endfunction
    function automatic logic [15:0] exp_bufen(input [7:0] v);
        return v[7] ? 16'h0000 : 16'h0001 << v[3:0];
    endfunction
    task test_done;
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input string s, input [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", s, e, g);
            fail_count++;
        end
    endtask
    task wb(input x, input [3:0] a, input [7:0] d);
        int n;
        @(posedge CLOCK);
        {CYC_I, STB_I, WE_I, ADR_I, DAT_I} <= {2'h3, x, a, 24'h0, d};
        n = 0;
        do @(posedge CLOCK) n++; while (ACK_O !== 1'b1 && n < 20);
        rd = DAT_O[7:0];
        if (n >= 20) fail_count++;
        {CYC_I, STB_I} <= 2'h0;
    endtask
    initial begin
        #2ms fail_count++;
        test_done;
    end
    initial begin
        repeat (16) @(posedge CLOCK);
        RST_N <= 1;
        wb(0, 4'h0, 0); chk("wrap", 8'h0F, rd);
        wb(0, 4'h4, 0); chk("trig", 8'h00, rd);
        repeat (20) begin
            it++;
            w = $random(seed);
            r = $random(seed);
            k = (w[3:0] == 4'h0) ? 4'h5 : w[3:0];
            t = w[7] ? (w & 8'hF3) : w;
            wb(1, 4'h0, {w[7:4], k}); wb(1, 4'h4, t);
            wb(0, 4'h0, 0); chk("wrap", k, rd);
            wb(0, 4'h4, 0); chk("trig", t & 8'h8F, rd);
            wb(0, 4'hC, 0); chk("unmapped", 0, rd);
            ANALOG_PINS <= r[15:0];
            DEDICATED_TRIGGER_INPUTS <= r[19:16];
            EXTERNAL_TRIGGER_ENABLE <= r[20];
            repeat (5) @(posedge CLOCK);
            chk("level", exp_level(t, r[15:0], r[19:16]), TRIGGER_LEVEL);
            chk("bufen", r[20] ? exp_bufen(t) : 16'h0000, INPUT_BUFFER_EN);
            START <= 1;
            @(posedge CLOCK) START <= 0;
            repeat (k + 2) @(posedge CLOCK) CONV_DONE <= 1;
            @(posedge CLOCK) CONV_DONE <= 0;
            @(posedge CLOCK) chk("chan", 1, CHANNEL);
            MULTI_CHANNEL_MODE <= 0;
            CONV_DONE <= 1;
            repeat (2) @(posedge CLOCK);
            CONV_DONE <= 0;
            MULTI_CHANNEL_MODE <= 1;
            @(posedge CLOCK) chk("hold", 1, CHANNEL);
            wb(1, 4'h4, t); chk("busy", 0, BUSY);
            @(posedge CLOCK) chk("abort", it, n_abort);
        end
        test_done;
    end
endmodule
